// >>> logic/abc_ctrl_regs.sv
// Summary of operation
// - activation request in full reset starts activation
// - request self-clears on progress, tone, reset
// - detected wake-up tone starts activation itself
// - line side tears down after three superframes
// - dropping deactivation request aborts the countdown
// - customer side dea answer means warm restart
// - customer side clears request; line side controller
// - update disable holds transmitted maintenance bits
// - ops, febe, crc bits always keep updating
// - customer enable passes channel data transparently
// - masked flags drive interrupt pin active
// - activation flag on status change, read clears
// - ops flag on buffer load, read clears
// - maintenance flag on buffer update, read clears
// - spare flag on buffer update, read clears
// - resets clear all five registers
// - first slot block sends ones or zeros
// - second slot block sends ones or zeros
// - blocks act on slots; swap both ways
// - received data gated by status and enables
`include "abc_params.svh"
`default_nettype none
module abc_ctrl_regs (
	input wire logic clk, // 100 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [`ABC_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [`ABC_DATA_W-1:0] pwdata, // apb write data
	output logic [`ABC_DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb unmapped address
	input wire logic soft_reset, // software reset level
	input wire logic line_side_mode_pin, // strap pin, high for lt
	input wire logic wake_tone_pin, // incoming tone detector
	input wire logic [`ABC_REG_W-1:0] act_status, // activation status
	input wire logic full_reset_state, // idle full-reset state
	input wire logic lt_wake_tone_sent, // tone sent, pulse
	input wire logic nt_deact_done, // nt deactivated, pulse
	input wire logic rx_dea_seen, // received turn-off bit
	input wire logic verified_act, // verified start-up bit
	input wire logic tdm_invert, // tdm_invert_control level
	input wire logic tx_sf_boundary, // transmit superframe edge
	input wire logic rx_eoc_load, // ops buffer loaded, pulse
	input wire logic rx_m4_update, // maint buffer updated, pulse
	input wire logic rx_spare_update, // spare buffer updated
	input wire logic dchan_event, // dchan_access_reg event
	input wire logic rd_act_status, // status register read
	input wire logic rd_ops_buf, // ops_channel_buffer read
	input wire logic rd_maint_buf, // maint_receive_buffer read
	input wire logic rd_spare_buf, // spare_bits_receive_buffer read
	input wire logic rd_dchan, // dchan_access_reg read
	input wire logic [7:0] line_rx_b1, // line first b channel
	input wire logic [7:0] line_rx_b2, // line second b channel
	input wire logic [7:0] tdm_rx_b1, // tdm_port first slot in
	input wire logic [7:0] tdm_rx_b2, // tdm_port second slot in
	output logic act_start, // start activation, level
	output logic warm_start, // next activation warm
	output logic teardown, // halt transmit, teardown
	output logic load_maint_tx, // load maintenance bits, pulse
	output logic load_ops_tx, // load ops/febe/crc, pulse
	output logic irq_b, // interrupt pin, active low
	output logic [7:0] tdm_tx_b1, // tdm_port first slot out
	output logic [7:0] tdm_tx_b2, // tdm_port second slot out
	output logic [7:0] line_tx_b1, // line first b channel out
	output logic [7:0] line_tx_b2 // line second b channel out
);
	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic pready_ff;
	logic pslverr_ff;
	logic [`ABC_DATA_W-1:0] prdata_ff;
	logic [`ABC_REG_W-1:0] act_ctrl_ff;
	logic [`ABC_REG_W-1:0] nxt_act_ctrl;
	logic [`ABC_REG_W-1:0] mask_ff;
	logic [`ABC_REG_W-1:0] tdm_ctrl_ff;
	abc_pkg::abc_deact_state_type state_ff;
	abc_pkg::abc_deact_state_type nxt_state;
	logic [1:0] sf_cnt_ff;
	logic [1:0] nxt_sf_cnt;
	logic warm_ff;
	wire [`ABC_REG_W-1:0] flags_vis;

	wire acc = psel & penable;
	wire first_acc = acc & ~pready_ff;
	wire done = acc & pready_ff;
	wire wr_en = done & pwrite & ~pslverr_ff;
	wire sel_act = (paddr == `ABC_OFS_ACT_CTRL);
	wire sel_stat = (paddr == `ABC_OFS_IRQ_STAT);
	wire sel_mask = (paddr == `ABC_OFS_IRQ_MASK);
	wire sel_tdm = (paddr == `ABC_OFS_TDM_CTRL);
	wire sel_dst = (paddr == `ABC_OFS_DEACT_STAT);
	wire addr_ok = sel_act | sel_stat | sel_mask | sel_tdm | sel_dst;
	wire wr_act = wr_en & sel_act;
	wire wr_mask = wr_en & sel_mask;
	wire wr_tdm = wr_en & sel_tdm;
	wire [`ABC_REG_W-1:0] wr_val = pwdata[`ABC_REG_W-1:0];
	wire [`ABC_DATA_W-1:0] dst_word =
		`ABC_DATA_W'({warm_ff, sf_cnt_ff, state_ff});
	wire [`ABC_DATA_W-1:0] rd_mux =
		sel_act ? `ABC_DATA_W'(act_ctrl_ff) :
		sel_stat ? `ABC_DATA_W'(flags_vis) :
		sel_mask ? `ABC_DATA_W'(mask_ff) :
		sel_tdm ? `ABC_DATA_W'(tdm_ctrl_ff) :
		sel_dst ? dst_word : `ABC_DATA_W'(`ABC_REG_RST);

	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata = prdata_ff;

	// one wait state so that every bus output comes from a flop
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= `ABC_DATA_W'(`ABC_REG_RST);
		end
		else
		begin
			pready_ff <= first_acc;
			pslverr_ff <= first_acc & ~addr_ok;
			prdata_ff <= (first_acc & ~pwrite) ? rd_mux : prdata_ff;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	logic [`ABC_REG_W-1:0] stat_prev_ff;
	logic lt_mode;
	logic wake_lvl;
	logic wake_prev_ff;

	wire aip_rise = act_status[`ABC_ST_AIP] & ~stat_prev_ff[`ABC_ST_AIP];
	wire wake_rise = wake_lvl & ~wake_prev_ff;
	wire linkup = act_status[`ABC_ST_LINKUP];
	wire sf_sync = act_status[`ABC_ST_SFSYNC];
	wire act_req = act_ctrl_ff[`ABC_ACT_REQ_BIT];
	wire deact_req = act_ctrl_ff[`ABC_DEACT_REQ_BIT];
	wire upd_dis = act_ctrl_ff[`ABC_UPD_DIS_BIT];
	wire cust_en = act_ctrl_ff[`ABC_CUST_EN_BIT];

	abc_sync3 u_mode_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(line_side_mode_pin),
		.q(lt_mode)
	);

	abc_sync3 u_wake_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(wake_tone_pin),
		.q(wake_lvl)
	);

	always_comb
	begin
		nxt_act_ctrl = act_ctrl_ff;
		if (soft_reset)
			nxt_act_ctrl = `ABC_REG_RST;
		else if (wr_act)
			nxt_act_ctrl = wr_val;
		else
		begin
			if (aip_rise | lt_wake_tone_sent)
				nxt_act_ctrl[`ABC_ACT_REQ_BIT] = 1'b0;
			if (!lt_mode && nt_deact_done)
				nxt_act_ctrl[`ABC_DEACT_REQ_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			act_ctrl_ff <= `ABC_REG_RST;
			mask_ff <= `ABC_REG_RST;
			tdm_ctrl_ff <= `ABC_REG_RST;
		end
		else
		begin
			act_ctrl_ff <= nxt_act_ctrl;
			mask_ff <= soft_reset ? `ABC_REG_RST :
				(wr_mask ? wr_val : mask_ff);
			tdm_ctrl_ff <= soft_reset ? `ABC_REG_RST :
				(wr_tdm ? wr_val : tdm_ctrl_ff);
		end
	end

	// ****************************************************************
	// activation and deactivation
	// ****************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_sf_cnt = sf_cnt_ff;
		case (state_ff)
			abc_pkg::abc_dst_idle:
			begin
				if (lt_mode && deact_req && linkup)
				begin
					nxt_state = abc_pkg::abc_dst_count;
					nxt_sf_cnt = `ABC_SF_ZERO;
				end
			end
			abc_pkg::abc_dst_count:
			begin
				if (!deact_req)
					nxt_state = abc_pkg::abc_dst_idle;
				else if (tx_sf_boundary && sf_cnt_ff == `ABC_SF_LAST)
					nxt_state = abc_pkg::abc_dst_down;
				else if (tx_sf_boundary)
					nxt_sf_cnt = sf_cnt_ff + `ABC_SF_ONE;
			end
			abc_pkg::abc_dst_down:
			begin
				// controller clears the request once torn down
				if (!deact_req)
					nxt_state = abc_pkg::abc_dst_idle;
			end
			default:
				nxt_state = abc_pkg::abc_dst_idle;
		endcase
		if (soft_reset)
		begin
			nxt_state = abc_pkg::abc_dst_idle;
			nxt_sf_cnt = `ABC_SF_ZERO;
		end
	end

	logic act_start_ff;
	logic teardown_ff;
	logic load_maint_ff;
	logic load_ops_ff;

	wire start_req = act_req & full_reset_state & ~soft_reset;
	wire start_tone = wake_rise & ~soft_reset;
	wire warm_set = wr_act & ~lt_mode & rx_dea_seen &
		wr_val[`ABC_DEACT_REQ_BIT];

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_ff <= abc_pkg::abc_dst_idle;
			sf_cnt_ff <= `ABC_SF_ZERO;
			stat_prev_ff <= `ABC_REG_RST;
			wake_prev_ff <= 1'b0;
			act_start_ff <= 1'b0;
			warm_ff <= 1'b0;
			teardown_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			sf_cnt_ff <= nxt_sf_cnt;
			stat_prev_ff <= act_status;
			wake_prev_ff <= wake_lvl;
			act_start_ff <= start_req | start_tone;
			warm_ff <= ~soft_reset & (warm_set | (warm_ff & ~act_start_ff));
			teardown_ff <= (nxt_state == abc_pkg::abc_dst_down);
		end
	end

	wire maint_go = tx_sf_boundary & ~upd_dis;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			load_maint_ff <= 1'b0;
			load_ops_ff <= 1'b0;
		end
		else
		begin
			load_maint_ff <= maint_go;
			load_ops_ff <= tx_sf_boundary;
		end
	end

	assign act_start = act_start_ff;
	assign warm_start = warm_ff;
	assign teardown = teardown_ff;
	assign load_maint_tx = load_maint_ff;
	assign load_ops_tx = load_ops_ff;

	// ****************************************************************
	// interrupt flags
	// ****************************************************************
	abc_evt_if evt [`ABC_NUM_FLAGS] ();
	wire [`ABC_NUM_FLAGS-1:0] flag_set;
	wire [`ABC_NUM_FLAGS-1:0] flag_clr;
	wire [`ABC_NUM_FLAGS-1:0] flag_q;
	logic irq_b_ff;

	assign flag_set[`ABC_F_ACT] = (act_status != stat_prev_ff);
	assign flag_clr[`ABC_F_ACT] = rd_act_status;
	assign flag_set[`ABC_F_DCHAN] = dchan_event;
	assign flag_clr[`ABC_F_DCHAN] = rd_dchan;
	assign flag_set[`ABC_F_OPS] = rx_eoc_load & sf_sync;
	assign flag_clr[`ABC_F_OPS] = rd_ops_buf;
	assign flag_set[`ABC_F_MAINT] = rx_m4_update & sf_sync;
	assign flag_clr[`ABC_F_MAINT] = rd_maint_buf;
	assign flag_set[`ABC_F_SPARE] = rx_spare_update & sf_sync;
	assign flag_clr[`ABC_F_SPARE] = rd_spare_buf;

	genvar gi;
	generate
		for (gi = 0; gi < `ABC_NUM_FLAGS; gi++)
		begin : g_flag
			assign evt[gi].set = flag_set[gi];
			assign evt[gi].clr = flag_clr[gi];
			assign evt[gi].wipe = soft_reset;
			assign flag_q[gi] = evt[gi].q;
			abc_event_flag u_flag (
				.clk(clk),
				.rst_b(rst_b),
				.evt(evt[gi])
			);
		end
	endgenerate

	// a pending status change survives the dchan read
	assign flags_vis[`ABC_F_ACT] = flag_q[`ABC_F_ACT] | flag_q[`ABC_F_DCHAN];
	assign flags_vis[`ABC_F_OPS] = flag_q[`ABC_F_OPS];
	assign flags_vis[`ABC_F_MAINT] = flag_q[`ABC_F_MAINT];
	assign flags_vis[`ABC_F_SPARE] = flag_q[`ABC_F_SPARE];

	wire irq_any = |(flags_vis & mask_ff);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_b_ff <= 1'b1;
		else
			irq_b_ff <= ~irq_any;
	end
	assign irq_b = irq_b_ff;

	// ****************************************************************
	// b channel path
	// ****************************************************************
	logic [7:0] tdm1_ff;
	logic [7:0] tdm2_ff;
	logic [7:0] line1_ff;
	logic [7:0] line2_ff;

	wire swap = tdm_ctrl_ff[`ABC_SWAP_BIT];
	wire rx_ok = linkup & sf_sync & act_status[`ABC_ST_AIP] &
		(cust_en | verified_act);
	wire [7:0] u1 = rx_ok ? line_rx_b1 : `ABC_BYTE_ONES;
	wire [7:0] u2 = rx_ok ? line_rx_b2 : `ABC_BYTE_ONES;
	wire [7:0] slot1 = swap ? u2 : u1;
	wire [7:0] slot2 = swap ? u1 : u2;
	wire [7:0] fill = tdm_invert ? `ABC_BYTE_ZERO : `ABC_BYTE_ONES;
	wire [7:0] out1 = tdm_ctrl_ff[`ABC_BLK1_BIT] ? fill : slot1;
	wire [7:0] out2 = tdm_ctrl_ff[`ABC_BLK2_BIT] ? fill : slot2;
	wire tx_ok = cust_en | verified_act;
	wire [7:0] t1 = swap ? tdm_rx_b2 : tdm_rx_b1;
	wire [7:0] t2 = swap ? tdm_rx_b1 : tdm_rx_b2;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tdm1_ff <= `ABC_BYTE_ONES;
			tdm2_ff <= `ABC_BYTE_ONES;
			line1_ff <= `ABC_BYTE_ONES;
			line2_ff <= `ABC_BYTE_ONES;
		end
		else
		begin
			tdm1_ff <= out1;
			tdm2_ff <= out2;
			line1_ff <= tx_ok ? t1 : `ABC_BYTE_ONES;
			line2_ff <= tx_ok ? t2 : `ABC_BYTE_ONES;
		end
	end

	assign tdm_tx_b1 = tdm1_ff;
	assign tdm_tx_b2 = tdm2_ff;
	assign line_tx_b1 = line1_ff;
	assign line_tx_b2 = line2_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_arm;
		state_ff == abc_pkg::abc_dst_idle && lt_mode && deact_req &&
			linkup && !soft_reset;
	endsequence
	sequence s_last_sf;
		state_ff == abc_pkg::abc_dst_count && deact_req &&
			sf_cnt_ff == `ABC_SF_LAST && tx_sf_boundary && !soft_reset;
	endsequence

	AST_ACT_START: assert property (
		act_req && full_reset_state && !soft_reset |=> act_start)
		else $error("activation not started on request");
	AST_REQ_CLR: assert property (
		$rose(act_status[`ABC_ST_AIP]) && !wr_act |=> !act_req)
		else $error("activation request not cleared");
	AST_WAKE: assert property (
		wake_lvl && !wake_prev_ff && !soft_reset |=> act_start)
		else $error("wake tone did not start activation");
	AST_ARM: assert property (
		s_arm |=> state_ff == abc_pkg::abc_dst_count &&
			sf_cnt_ff == `ABC_SF_ZERO)
		else $error("countdown not armed");
	AST_TEARDOWN: assert property (
		s_last_sf |=> teardown && state_ff == abc_pkg::abc_dst_down)
		else $error("no teardown after third superframe");
	AST_ABORT: assert property (
		state_ff == abc_pkg::abc_dst_count && !deact_req |=> !teardown)
		else $error("deactivation not aborted");
	AST_NT_CLR: assert property (
		!lt_mode && nt_deact_done && !wr_act |=> !deact_req)
		else $error("customer side request not cleared");
	AST_HOLD: assert property (
		tx_sf_boundary && upd_dis |=> !load_maint_tx && load_ops_tx)
		else $error("maintenance load not held");
	AST_IRQ: assert property (
		(flags_vis & mask_ff) != `ABC_REG_RST |=> !irq_b)
		else $error("interrupt pin not active");
	AST_FLAG: assert property (
		act_status != stat_prev_ff && !soft_reset |=>
			flags_vis[`ABC_F_ACT])
		else $error("activation flag not set");
	AST_OPS_FLAG: assert property (
		rx_eoc_load && sf_sync && !soft_reset |=> flags_vis[`ABC_F_OPS])
		else $error("ops flag not set");
	AST_RESET: assert property (
		soft_reset |=> act_ctrl_ff == `ABC_REG_RST &&
			mask_ff == `ABC_REG_RST && tdm_ctrl_ff == `ABC_REG_RST &&
			flags_vis == `ABC_REG_RST)
		else $error("registers not cleared by reset");
	AST_BLOCK1: assert property (
		tdm_ctrl_ff[`ABC_BLK1_BIT] && !tdm_invert && !soft_reset |=>
			tdm_tx_b1 == `ABC_BYTE_ONES)
		else $error("first slot not blocked");
	AST_GATE: assert property (
		!linkup && !tdm_ctrl_ff[`ABC_BLK2_BIT] |=>
			tdm_tx_b2 == `ABC_BYTE_ONES)
		else $error("received data not gated");
endmodule : abc_ctrl_regs
`default_nettype wire

// >>> logic/abc_params.svh
`ifndef ABC_PARAMS_SVH
`define ABC_PARAMS_SVH

// ****************************************************************
// bus layout
// ****************************************************************
`define ABC_ADDR_W 8
`define ABC_DATA_W 32
`define ABC_REG_W 4
`define ABC_REG_RST 4'h0
`define ABC_OFS_ACT_CTRL 8'h00
`define ABC_OFS_IRQ_STAT 8'h04
`define ABC_OFS_IRQ_MASK 8'h08
`define ABC_OFS_TDM_CTRL 8'h0c
`define ABC_OFS_DEACT_STAT 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define ABC_ACT_REQ_BIT 3
`define ABC_DEACT_REQ_BIT 2
`define ABC_UPD_DIS_BIT 1
`define ABC_CUST_EN_BIT 0
`define ABC_F_ACT 3
`define ABC_F_OPS 2
`define ABC_F_MAINT 1
`define ABC_F_SPARE 0
`define ABC_F_DCHAN 4
`define ABC_NUM_FLAGS 5
`define ABC_BLK1_BIT 2
`define ABC_BLK2_BIT 1
`define ABC_SWAP_BIT 0
`define ABC_ST_LINKUP 3
`define ABC_ST_SFSYNC 1
`define ABC_ST_AIP 0

// ****************************************************************
// counts and fill values
// ****************************************************************
// three transmitted superframes before teardown: last index is two
`define ABC_SF_LAST 2'h2
`define ABC_SF_ZERO 2'h0
`define ABC_SF_ONE 2'h1
`define ABC_BYTE_ONES 8'hff
`define ABC_BYTE_ZERO 8'h00

`endif

// >>> logic/abc_pkg.sv
`default_nettype none
package abc_pkg;
	typedef enum logic [1:0]
	{
		abc_dst_idle = 2'b00,
		abc_dst_count = 2'b01,
		abc_dst_down = 2'b10
	} abc_deact_state_type;
endpackage : abc_pkg
`default_nettype wire

// >>> logic/abc_evt_if.sv
`default_nettype none
interface abc_evt_if;
	logic set;
	logic clr;
	logic wipe;
	logic q;
	modport flag (input set, input clr, input wipe, output q);
	modport ctrl (output set, output clr, output wipe, input q);
endinterface : abc_evt_if
`default_nettype wire

// >>> logic/abc_event_flag.sv
`default_nettype none
module abc_event_flag (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	abc_evt_if.flag evt // set, clear, wipe and state
);
	logic q_ff;
	logic nxt_q;

	// a set in the clearing cycle wins; only a reset wipe beats it
	assign nxt_q = evt.wipe ? 1'b0 : (evt.set | (q_ff & ~evt.clr));
	assign evt.q = q_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q_ff <= 1'b0;
		else
			q_ff <= nxt_q;
	end
endmodule : abc_event_flag
`default_nettype wire

// >>> logic/abc_sync3.sv
`default_nettype none
module abc_sync3 (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic d, // asynchronous level
	output logic q // filtered level
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic q_ff;
	logic agree;

	// the first stage feeds only the second
	assign agree = (s2_ff == s3_ff);
	assign q = q_ff;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			q_ff <= 1'b0;
		end
		else
		begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= agree ? s3_ff : q_ff;
		end
	end
endmodule : abc_sync3
`default_nettype wire

// >>> verification/abc_far_model.sv
`default_nettype none
// line-side framer pacing: one transmit superframe edge per period
module abc_far_model (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic run, // frames flowing on the line
	output logic sf_edge // transmit superframe boundary pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_ff;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_ff <= 4'h0;
			sf_edge <= 1'b0;
		end
		else
		begin
			cnt_ff <= run ? cnt_ff + 4'h1 : 4'h0;
			sf_edge <= run && (cnt_ff == 4'hf);
		end
	end
endmodule : abc_far_model
`default_nettype wire

// >>> verification/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, soft_reset = 1'b0, line_side_mode_pin = 1'b1;
	logic wake_tone_pin = 1'b0, full_reset_state = 1'b0, run = 1'b0;
	logic lt_wake_tone_sent = 1'b0, nt_deact_done = 1'b0;
	logic rx_dea_seen = 1'b0, verified_act = 1'b0, tdm_invert = 1'b0;
	logic [7:0] paddr = 8'h00, line_rx_b1 = 8'h00, line_rx_b2 = 8'h00;
	logic [7:0] tdm_rx_b1 = 8'h00, tdm_rx_b2 = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0] act_status = 4'h0, m, fl;
	logic [4:0] ev = 5'h0, rdp = 5'h0;
	logic [31:0] prdata;
	logic pready, pslverr, act_start, warm_start, teardown, er;
	logic load_maint_tx, load_ops_tx, irq_b, tx_sf_boundary;
	logic [7:0] tdm_tx_b1, tdm_tx_b2, line_tx_b1, line_tx_b2;
	int fails = 0, samples_checked = 0, bcnt = 0, mcnt = 0, ocnt = 0;
	int seed = 32'he055, i, n, b0, tcnt = 0;

	always #5 clk = ~clk;

	abc_far_model far (.clk, .rst_b, .run, .sf_edge(tx_sf_boundary));

	abc_ctrl_regs DUT (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .soft_reset,
		.line_side_mode_pin, .wake_tone_pin, .act_status,
		.full_reset_state, .lt_wake_tone_sent, .nt_deact_done,
		.rx_dea_seen, .verified_act, .tdm_invert, .tx_sf_boundary,
		.rx_eoc_load(ev[2]), .rx_m4_update(ev[1]),
		.rx_spare_update(ev[0]), .dchan_event(ev[4]),
		.rd_act_status(rdp[3]), .rd_ops_buf(rdp[2]),
		.rd_maint_buf(rdp[1]), .rd_spare_buf(rdp[0]), .rd_dchan(rdp[4]),
		.line_rx_b1, .line_rx_b2, .tdm_rx_b1, .tdm_rx_b2, .act_start,
		.warm_start, .teardown, .load_maint_tx, .load_ops_tx, .irq_b,
		.tdm_tx_b1, .tdm_tx_b2, .line_tx_b1, .line_tx_b2);

	always @(posedge clk)
	begin
		bcnt <= bcnt + int'(tx_sf_boundary);
		mcnt <= mcnt + int'(load_maint_tx);
		ocnt <= ocnt + int'(load_ops_tx);
		tcnt <= tcnt + int'(teardown);
	end

	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc

	// waits for k more superframe edges
	task wsf(input int k);
		int t;
		t = bcnt + k;
		while (bcnt < t)
			@(posedge clk);
	endtask : wsf

	// one apb transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task done(input string s);
		$display("test %s done", s);
	endtask : done

	// expected tdm slot byte: swap first, blocking by slot position
	function logic [7:0] slot(input logic [3:0] c, input logic inv,
		input logic [7:0] a, input logic [7:0] b, input logic sec);
		logic [7:0] v;
		v = (c[0] ^ sec) ? b : a;
		if (sec ? c[1] : c[2])
			v = inv ? 8'h00 : 8'hff;
		return v;
	endfunction : slot

	task finish_test;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	initial
	begin
		cyc(20000);
		fails++;
		finish_test();
	end

	initial
	begin
		cyc(8);
		rst_b <= 1'b1;
		run <= 1'b1;
		cyc(6);
		for (i = 0; i < 5; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b1, 8'h04, 32'hf);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1);
		chk(irq_b, 1'b1);
		done("reset");
		full_reset_state <= 1'b1;
		apb(1'b1, 8'h00, 32'h8); // single request
		cyc(2);
		chk(act_start, 1'b1);
		act_status <= 4'h1;
		cyc(3);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		full_reset_state <= 1'b0;
		cyc(2);
		chk(act_start, 1'b0);
		wake_tone_pin <= 1'b1;
		n = 0;
		while (act_start !== 1'b1 && n < 12)
		begin
			cyc(1);
			n++;
		end
		chk(n < 12, 1'b1);
		wake_tone_pin <= 1'b0;
		done("activation");
		m = 4'($random(seed)) | 4'h1;
		apb(1'b1, 8'h08, {28'h0, m});
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, {28'h0, m});
		act_status <= 4'hb;
		ev <= 5'h17;
		cyc(1);
		ev <= 5'h0;
		cyc(3);
		apb(1'b0, 8'h04, 32'h0);
		fl = 4'hf;
		chk(rd, 32'hf);
		for (i = 4; i >= 0; i--)
		begin
			rdp[i] <= 1'b1;
			cyc(1);
			rdp <= 5'h0;
			if (i < 4)
				fl[i] = 1'b0;
			cyc(3);
			apb(1'b0, 8'h04, 32'h0);
			chk(rd, {28'h0, fl});
			chk(irq_b, ~|(fl & m));
		end
		// no buffer events without superframe sync
		act_status <= 4'h9;
		ev <= 5'h07;
		cyc(1);
		ev <= 5'h0;
		act_status <= 4'hb;
		cyc(3);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h8);
		done("interrupts");
		chk(tdm_tx_b1, 8'hff);
		apb(1'b1, 8'h00, 32'h1); // enable after start-up
		for (i = 0; i < 16; i++)
		begin
			line_rx_b1 <= 8'($random(seed));
			line_rx_b2 <= 8'($random(seed));
			tdm_rx_b1 <= 8'($random(seed));
			tdm_rx_b2 <= 8'($random(seed));
			tdm_invert <= i[3];
			apb(1'b1, 8'h0c, {29'h0, i[2:0]}); // reserved zero
			cyc(3);
			chk(tdm_tx_b1, slot(4'(i), i[3], line_rx_b1, line_rx_b2,
				1'b0));
			chk(tdm_tx_b2, slot(4'(i), i[3], line_rx_b1, line_rx_b2,
				1'b1));
			chk(line_tx_b1, i[0] ? tdm_rx_b2 : tdm_rx_b1);
			chk(line_tx_b2, i[0] ? tdm_rx_b1 : tdm_rx_b2);
		end
		done("channels");
		wsf(1);
		apb(1'b1, 8'h00, 32'h3);
		b0 = mcnt;
		n = ocnt;
		wsf(2);
		cyc(3);
		chk(mcnt - b0, 0);
		chk(ocnt - n, 2);
		wsf(1);
		apb(1'b1, 8'h00, 32'h5);
		b0 = mcnt;
		wsf(2);
		cyc(3);
		chk(teardown, 1'b0);
		chk(mcnt - b0, 2);
		wsf(1);
		cyc(3);
		chk(teardown, 1'b1);
		apb(1'b1, 8'h00, 32'h1); // controller clears
		cyc(2);
		chk(teardown, 1'b0);
		wsf(1);
		b0 = tcnt;
		apb(1'b1, 8'h00, 32'h5);
		wsf(1);
		apb(1'b1, 8'h00, 32'h1);
		wsf(4);
		chk(teardown, 1'b0);
		chk(tcnt - b0, 0);
		done("deactivation");
		// customer side: answer a received turn-off bit
		line_side_mode_pin <= 1'b0;
		rx_dea_seen <= 1'b1;
		cyc(6);
		apb(1'b1, 8'h00, 32'h5);
		cyc(2);
		chk(warm_start, 1'b1);
		nt_deact_done <= 1'b1;
		cyc(1);
		nt_deact_done <= 1'b0;
		rx_dea_seen <= 1'b0;
		cyc(2);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		line_side_mode_pin <= 1'b1;
		full_reset_state <= 1'b1;
		apb(1'b1, 8'h00, 32'h9); // single request
		cyc(3);
		chk(warm_start, 1'b0);
		cyc(6);
		lt_wake_tone_sent <= 1'b1;
		cyc(1);
		lt_wake_tone_sent <= 1'b0;
		full_reset_state <= 1'b0;
		cyc(2);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		done("customer side");
		apb(1'b1, 8'h00, 32'h6);
		soft_reset <= 1'b1;
		cyc(1);
		soft_reset <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0);
		end
		done("soft reset");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
